// ===== acap_defines.svh
// Constants for the ADC capture block: conversion control and dual-line serial receiver.
// Assumes a 25 MHz core clock and an external ADC that returns results on two serial lines.
//
// Behaviour
// RULE_01 - Receiver samples data on serial clock falling edge.
// RULE_02 - Frame sync is active low, starts word.
// RULE_03 - Clock and frame come from outside, receiver enabled.
// RULE_04 - One frame per word, MSB first, zero fill.
// RULE_05 - Both result lines captured in parallel.
// RULE_06 - Word length code 1111 or 1101.
// RULE_07 - Power-down uses code 1001, eight-clock burst; the conversion clock here still runs the full 18 periods.
// RULE_08 - ADC samples at chip select falling edge.
// RULE_09 - Result belongs to same frame, no pipeline.
// RULE_10 - Results on two lines or in succession.
// RULE_11 - Results are 12-bit binary or twos complement.
// RULE_12 - Control lines here; serial port moves data.
// RULE_13 - Conversions launched by internal or external trigger.
// RULE_14 - Each converter picks among three channels.
// RULE_15 - Dual conversion with readout within 437.5 ns; chip select stays low for 18 conversion clock periods of 320 ns.
// RULE_16 - Mode input selects single-ended or differential.
// RULE_17 - Range input selects reference or twice reference.
// RULE_18 - Address, mode, range driven before chip select.
`ifndef ACAP_DEFINES_SVH
`define ACAP_DEFINES_SVH

`define ACAP_WLEN_16 4'hF
`define ACAP_WLEN_14 4'hD
`define ACAP_WLEN_PD 4'h9
`define ACAP_WORD_W 16
`define ACAP_FIFO_DEPTH 8
`define ACAP_FIFO_AW 3
// Conversion clock divider: a tick every fourth core cycle toggles the ADC clock, giving core/8.
`define ACAP_CLK_DIV 4'h3
// Set-up cycles between driving address and pulling chip select low.
`define ACAP_SETUP_CYC 4'h2
// Chip select low for this many conversion clock periods (16 bits plus slack).
`define ACAP_CONV_PERIODS 5'h12
`define ACAP_CONV_NS 437.5
`define ACAP_CLK_MHZ 25

`endif

// ===== acap_pkg.sv
// Types for the ADC capture block.
// Assumes acap_defines.svh is available for the numbers.
package acap_pkg;
    typedef enum logic [1:0] {ACAP_IDLE, ACAP_SETUP, ACAP_CONV} acap_state_t;
endpackage

// ===== acap_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
module acap_fifo
    import acap_pkg::*;
#(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8,
    parameter int AW = 3
)
(
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst_b,
    // Write side.
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Read side.
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic [AW-1:0] next_wr_ptr;
    logic [AW-1:0] next_rd_ptr;
    logic [AW:0] next_count;
    logic do_wr;
    logic do_rd;

    // Full and empty come straight from the occupancy count.
    assign in_ready = (count != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];
    assign do_wr = in_valid && in_ready;
    assign do_rd = out_valid && out_ready;

    // Pointer and count updates.
    always_comb
    begin
        next_wr_ptr = do_wr ? AW'(wr_ptr + 1'b1) : wr_ptr;
        next_rd_ptr = do_rd ? AW'(rd_ptr + 1'b1) : rd_ptr;
        next_count = count;
        if (do_wr && !do_rd)
        begin
            next_count = (AW+1)'(count + 1'b1);
        end
        else if (do_rd && !do_wr)
        begin
            next_count = (AW+1)'(count - 1'b1);
        end
    end

    // Storage is written only on accepted words, so it needs no reset.
    always_ff @(posedge core_clk)
    begin
        if (do_wr)
        begin
            mem[wr_ptr] <= in_data;
        end
    end

    // Register pointers.
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else
        begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
    end

    fifo_bound_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        count <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule // acap_fifo

// ===== acap_capture.sv
// ADC capture top: conversion control and dual-line serial receiver.
// Assumes the ADC serial clock and frame arrive asynchronously and are much slower than core_clk.
`timescale 1ns/1ps
`include "acap_defines.svh"
module acap_capture
    import acap_pkg::*;
(
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst_b,
    // Trigger sources and selection.
    input wire logic trig_internal,
    input wire logic trig_external,
    input wire logic trig_select_external,
    // Conversion settings.
    input wire logic [2:0] channel_select,
    input wire logic input_mode_cfg,
    input wire logic input_range_cfg,
    input wire logic power_down_req,
    input wire logic word14_select,
    // Receiver settings status.
    input wire logic rx_port_enable,
    output logic [3:0] rx_word_length,
    output logic rx_clock_edge_select,
    output logic rx_frame_polarity,
    output logic busy,
    output logic overflow,
    // ADC control pins.
    output logic conv_cs_b,
    output logic conversion_clock,
    output logic [2:0] channel_address,
    output logic input_mode_select,
    output logic input_range_select,
    // ADC serial pins.
    input wire logic rx_serial_clock,
    input wire logic rx_frame_sync_b,
    input wire logic result_line_a,
    input wire logic result_line_b,
    // Result stream.
    output logic res_valid,
    input wire logic res_ready,
    output logic [31:0] res_data
);
    acap_state_t state;
    acap_state_t next_state;
    logic [3:0] div_cnt;
    logic [3:0] next_div_cnt;
    logic [4:0] per_cnt;
    logic [4:0] next_per_cnt;
    logic [2:0] addr;
    logic [2:0] next_addr;
    logic mode;
    logic next_mode;
    logic range;
    logic next_range;
    logic sclk_q;
    logic next_sclk_q;
    logic [3:0] wlen;
    logic [3:0] next_wlen;
    logic div_tick;
    logic trig;
    logic trig_ext_prev;
    logic trig_ext_edge;
    // Synchronisers: stage one feeds stage two only.
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] sync_prev;
    logic sync_b1;
    logic sync_b2;
    logic sclk_fall;
    logic frame_act;
    logic [15:0] sh_a;
    logic [15:0] sh_b;
    logic [15:0] next_sh_a;
    logic [15:0] next_sh_b;
    logic [4:0] bit_cnt;
    logic [4:0] next_bit_cnt;
    logic in_word;
    logic next_in_word;
    logic push;
    logic next_push;
    logic [31:0] push_data;
    logic [31:0] next_push_data;
    logic fifo_ready;
    logic next_overflow;

    function automatic logic [15:0] zero_fill(input logic [15:0] v, input logic [4:0] n);
        logic [15:0] m;
        m = 16'hFFFF >> (5'h10 - n);
        return v & m;
    endfunction

    // Receiver settings are fixed strobes: falling edge, active low frame, external clock.
    assign rx_clock_edge_select = 1'b0; // [RULE_01]
    assign rx_frame_polarity = 1'b1; // [RULE_02]
    assign rx_word_length = wlen;
    assign busy = (state != ACAP_IDLE);
    assign channel_address = addr;
    assign input_mode_select = mode;
    assign input_range_select = range;
    assign conversion_clock = sclk_q;
    assign conv_cs_b = (state != ACAP_CONV);
    assign div_tick = (div_cnt == `ACAP_CLK_DIV);
    assign trig_ext_edge = sync2[3] && !trig_ext_prev;
    // Trigger source is chosen by the select input.
    assign trig = trig_select_external ? trig_ext_edge : trig_internal; // [RULE_13]
    assign sclk_fall = sync_prev[0] && !sync2[0]; // [RULE_01]
    assign frame_act = !sync2[1]; // [RULE_02] [RULE_03]

    // Conversion controller: divider, scheduling and pin setup.
    always_comb
    begin
        next_state = state;
        next_div_cnt = div_tick ? 4'h0 : 4'(div_cnt + 1'b1);
        next_sclk_q = sclk_q;
        next_per_cnt = per_cnt;
        next_addr = addr;
        next_mode = mode;
        next_range = range;
        next_wlen = wlen;
        unique case (state)
            ACAP_IDLE:
            begin
                next_sclk_q = 1'b1;
                if (trig)
                begin
                    // Pins settle before chip select falls.
                    next_addr = channel_select; // [RULE_18]
                    next_mode = input_mode_cfg; // [RULE_16]
                    next_range = input_range_cfg; // [RULE_17]
                    next_wlen = power_down_req ? `ACAP_WLEN_PD : // [RULE_07]
                        (word14_select ? `ACAP_WLEN_14 : `ACAP_WLEN_16); // [RULE_06]
                    next_per_cnt = 5'(`ACAP_SETUP_CYC);
                    next_state = ACAP_SETUP;
                end
            end
            ACAP_SETUP:
            begin
                next_per_cnt = 5'(per_cnt - 1'b1);
                if (per_cnt == 5'h01)
                begin
                    next_per_cnt = 5'(`ACAP_CONV_PERIODS);
                    next_state = ACAP_CONV; // [RULE_12] [RULE_08]
                end
            end
            ACAP_CONV:
            begin
                if (div_tick)
                begin
                    next_sclk_q = !sclk_q;
                    if (sclk_q)
                    begin
                        next_per_cnt = 5'(per_cnt - 1'b1); // [RULE_15]
                        if (per_cnt == 5'h01)
                        begin
                            next_state = ACAP_IDLE;
                        end
                    end
                end
            end
        endcase
    end

    // Receiver: both lines shift together on each falling serial clock edge inside an active frame while rx_port_enable is high.
    always_comb
    begin
        next_sh_a = sh_a;
        next_sh_b = sh_b;
        next_bit_cnt = bit_cnt;
        next_in_word = in_word;
        next_push = 1'b0;
        next_push_data = push_data;
        next_overflow = overflow;
        if (!rx_port_enable || !frame_act)
        begin
            next_in_word = frame_act && in_word;
            if (!frame_act)
            begin
                next_in_word = 1'b0;
                next_bit_cnt = 5'h00;
            end
        end
        else if (sclk_fall)
        begin
            // One frame per word, most significant bit first.
            next_sh_a = {sh_a[14:0], sync2[2]}; // [RULE_04] [RULE_05]
            next_sh_b = {sh_b[14:0], sync_b2}; // [RULE_05]
            next_bit_cnt = 5'(bit_cnt + 1'b1);
            next_in_word = 1'b1;
            if (5'(bit_cnt + 1'b1) == 5'(wlen + 1'b1))
            begin
                next_push = (wlen != `ACAP_WLEN_PD);
                next_push_data = {zero_fill({sh_b[14:0], sync_b2}, 5'(wlen + 1'b1)),
                    zero_fill({sh_a[14:0], sync2[2]}, 5'(wlen + 1'b1))}; // [RULE_04]
                next_bit_cnt = 5'h00;
            end
        end
        if (push && !fifo_ready)
        begin
            next_overflow = 1'b1;
        end
    end

    // Register state and synchronise pins.
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state <= ACAP_IDLE;
            div_cnt <= 4'h0;
            per_cnt <= 5'h00;
            addr <= 3'h0;
            mode <= 1'b0;
            range <= 1'b0;
            sclk_q <= 1'b1;
            wlen <= `ACAP_WLEN_16;
            // The trigger stage resets low like its idle pin, so no false edge follows reset.
            sync1 <= 4'h7;
            sync2 <= 4'h7;
            sync_prev <= 4'h7;
            sync_b1 <= 1'b0;
            sync_b2 <= 1'b0;
            trig_ext_prev <= 1'b0;
            sh_a <= 16'h0000;
            sh_b <= 16'h0000;
            bit_cnt <= 5'h00;
            in_word <= 1'b0;
            push <= 1'b0;
            push_data <= 32'h0000_0000;
            overflow <= 1'b0;
        end
        else
        begin
            state <= next_state;
            div_cnt <= next_div_cnt;
            per_cnt <= next_per_cnt;
            addr <= next_addr;
            mode <= next_mode;
            range <= next_range;
            sclk_q <= next_sclk_q;
            wlen <= next_wlen;
            sync1 <= {trig_external, result_line_a, rx_frame_sync_b, rx_serial_clock};
            sync2 <= sync1;
            sync_prev <= sync2;
            sync_b1 <= result_line_b;
            sync_b2 <= sync_b1;
            trig_ext_prev <= sync2[3];
            sh_a <= next_sh_a;
            sh_b <= next_sh_b;
            bit_cnt <= next_bit_cnt;
            in_word <= next_in_word;
            push <= next_push;
            push_data <= next_push_data;
            overflow <= next_overflow;
        end
    end

    acap_fifo #(
        .WIDTH(32),
        .DEPTH(`ACAP_FIFO_DEPTH),
        .AW(`ACAP_FIFO_AW)
    ) u_fifo (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .in_valid(push),
        .in_ready(fifo_ready),
        .in_data(push_data),
        .out_valid(res_valid),
        .out_ready(res_ready),
        .out_data(res_data)
    );

    cs_after_setup_a: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE_18]
        $fell(conv_cs_b) |-> $past(state) == ACAP_SETUP && channel_address == $past(channel_address, 2))
        else $error("chip select fell without settled address");
    cs_falls_after_trig_a: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE_13]
        (state == ACAP_IDLE && trig) |-> ##3 !conv_cs_b) else $error("conversion not launched");
    wlen_legal_a: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE_06]
        wlen == `ACAP_WLEN_16 || wlen == `ACAP_WLEN_14 || wlen == `ACAP_WLEN_PD)
        else $error("illegal word length");
    pd_no_push_a: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE_07]
        wlen == `ACAP_WLEN_PD && $stable(wlen) |-> ##1 !push) else $error("power-down burst pushed data");
    frame_resets_a: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE_02]
        !frame_act |=> bit_cnt == 5'h00) else $error("bit count kept outside frame");
    shift_on_fall_a: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE_01]
        (rx_port_enable && frame_act && sclk_fall) |=> sh_a[0] == $past(sync2[2]))
        else $error("line a not shifted on falling edge");
    disabled_idle_a: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE_03]
        !rx_port_enable |=> !push) else $error("receiver pushed while disabled");
    zero_fill_a: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE_04]
        push && wlen == `ACAP_WLEN_14 |-> push_data[15:14] == 2'h0 && push_data[31:30] == 2'h0)
        else $error("upper bits not zero filled");
    cs_pulse_a: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE_12]
        !conv_cs_b |-> busy) else $error("chip select low while idle");
    cover_conv_c: cover property (@(posedge core_clk) disable iff (!rst_b) $rose(conv_cs_b));
    cover_push_c: cover property (@(posedge core_clk) disable iff (!rst_b) push && fifo_ready);
    cover_full_c: cover property (@(posedge core_clk) disable iff (!rst_b) push && !fifo_ready);
endmodule // acap_capture

// ===== acap_adc_model.sv
// Behavioural model of the dual 12-bit converter behind the capture block.
// Assumes the bench sets the codes and the frame length before each chip select fall.
`timescale 1ns/1ps
module acap_adc_model
(
    // Control pins from the capture block.
    input wire logic conv_cs_b,
    input wire logic [2:0] channel_address,
    input wire logic input_mode_select,
    input wire logic input_range_select,
    // Codes and frame length chosen by the bench.
    input wire logic [11:0] code_a,
    input wire logic [11:0] code_b,
    input int nbits,
    // Serial pins towards the capture block.
    output logic rx_serial_clock,
    output logic rx_frame_sync_b,
    output logic result_line_a,
    output logic result_line_b
);
    logic [15:0] word_a;
    logic [15:0] word_b;
    logic [2:0] sampled_ch;
    logic sampled_mode;
    logic sampled_range;
    int i;

    // One frame per chip select fall; the clock stands high between frames.
    initial
    begin
        rx_serial_clock = 1'b1;
        rx_frame_sync_b = 1'b1;
        result_line_a = 1'b0;
        result_line_b = 1'b1;
        forever
        begin
            @(negedge conv_cs_b);
            sampled_ch = channel_address;
            sampled_mode = input_mode_select;
            sampled_range = input_range_select;
            word_a = {4'h0, code_a};
            word_b = {4'h0, code_b};
            #100;
            rx_frame_sync_b = 1'b0;
            for (i = nbits - 1; i >= 0; i--)
            begin
                result_line_a = word_a[i];
                result_line_b = word_b[i];
                #160 rx_serial_clock = 1'b0;
                #160 rx_serial_clock = 1'b1;
            end
            // Released lines show the inverse so a stale bit never passes for data.
            rx_frame_sync_b = 1'b1;
            result_line_a = ~result_line_a;
            result_line_b = ~result_line_b;
        end
    end
endmodule // acap_adc_model

// ===== testbench.sv
// Self-checking bench for the capture block with a converter model on its serial side.
// Assumes the design and its FIFO are compiled first; results are checked against a queue.
`timescale 1ns/1ps
module testbench
    import acap_pkg::*;
;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic trig_internal = 1'b0, trig_external = 1'b0, trig_select_external = 1'b0;
    logic [2:0] channel_select = 3'h0;
    logic input_mode_cfg = 1'b0, input_range_cfg = 1'b0, power_down_req = 1'b0, word14_select = 1'b0;
    logic rx_port_enable = 1'b1, res_ready = 1'b0;
    logic [3:0] rx_word_length;
    logic rx_clock_edge_select, rx_frame_polarity, busy, overflow, conv_cs_b, conversion_clock;
    logic [2:0] channel_address;
    logic input_mode_select, input_range_select;
    logic rx_serial_clock, rx_frame_sync_b, result_line_a, result_line_b, res_valid;
    logic [31:0] res_data;
    logic [11:0] code_a = 12'h000, code_b = 12'h000;
    int nbits = 16;
    int fail_count = 0, n_tests = 0, cycles = 0;
    logic [31:0] q[$];
    logic ovf = 1'b0;
    int k;

    acap_capture acap_capture_inst (.core_clk(core_clk), .rst_b(rst_b), .trig_internal(trig_internal),
        .trig_external(trig_external), .trig_select_external(trig_select_external),
        .channel_select(channel_select), .input_mode_cfg(input_mode_cfg), .input_range_cfg(input_range_cfg),
        .power_down_req(power_down_req), .word14_select(word14_select), .rx_port_enable(rx_port_enable),
        .rx_word_length(rx_word_length), .rx_clock_edge_select(rx_clock_edge_select),
        .rx_frame_polarity(rx_frame_polarity), .busy(busy), .overflow(overflow), .conv_cs_b(conv_cs_b),
        .conversion_clock(conversion_clock), .channel_address(channel_address),
        .input_mode_select(input_mode_select), .input_range_select(input_range_select),
        .rx_serial_clock(rx_serial_clock), .rx_frame_sync_b(rx_frame_sync_b), .result_line_a(result_line_a),
        .result_line_b(result_line_b), .res_valid(res_valid), .res_ready(res_ready), .res_data(res_data));

    acap_adc_model acap_adc_model_inst (.conv_cs_b(conv_cs_b), .channel_address(channel_address),
        .input_mode_select(input_mode_select), .input_range_select(input_range_select), .code_a(code_a),
        .code_b(code_b), .nbits(nbits), .rx_serial_clock(rx_serial_clock), .rx_frame_sync_b(rx_frame_sync_b),
        .result_line_a(result_line_a), .result_line_b(result_line_b));

    // Core clock at 25 MHz.
    always #20 core_clk = ~core_clk;

    // Prints the counts and the verdict, then stops the run.
    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Cuts a hang short; the longest run needs well under this many cycles.
    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 15000)
        begin
            fail_count++;
            end_sim();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_tests++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One conversion: settings, trigger, pin checks while chip select is low, then the expected word.
    task automatic run(input bit ext, input bit pd, input bit w14, input bit en);
        int n;
        int t;
        logic prev;
        logic [2:0] ch;
        logic md;
        logic rg;
        ch = 3'($urandom);
        md = 1'($urandom);
        rg = 1'($urandom);
        @(posedge core_clk);
        code_a <= 12'($urandom);
        code_b <= 12'($urandom);
        nbits <= pd ? 8 : (w14 ? 14 : 16);
        channel_select <= ch;
        input_mode_cfg <= md;
        input_range_cfg <= rg;
        power_down_req <= pd;
        word14_select <= w14;
        trig_select_external <= ext;
        rx_port_enable <= en;
        if (ext)
        begin
            @(posedge core_clk) trig_internal <= 1'b1;
            @(posedge core_clk) trig_internal <= 1'b0;
            repeat (8) @(posedge core_clk);
            check(conv_cs_b, 1'b1, "cs_refused");
            trig_external <= 1'b1;
        end
        else
            trig_internal <= 1'b1;
        @(posedge core_clk) trig_internal <= 1'b0;
        repeat (4) @(posedge core_clk);
        trig_external <= 1'b0;
        n = 0;
        while (conv_cs_b !== 1'b0 && n < 20)
        begin
            @(negedge core_clk);
            n++;
        end
        check(conv_cs_b, 1'b0, "cs_low");
        check(channel_address, ch, "channel_address");
        check({acap_adc_model_inst.sampled_ch, acap_adc_model_inst.sampled_mode,
            acap_adc_model_inst.sampled_range}, {ch, md, rg}, "sampled_pins");
        check(busy, 1'b1, "busy");
        check({input_mode_select, input_range_select}, {md, rg}, "mode_range");
        check(rx_word_length, pd ? 4'h9 : (w14 ? 4'hD : 4'hF), "word_length");
        t = 0;
        prev = conversion_clock;
        while (conv_cs_b === 1'b0 && n < 400)
        begin
            @(negedge core_clk);
            if (conversion_clock !== prev)
                t++;
            prev = conversion_clock;
            n++;
        end
        check(32'(t >= 32), 32'h1, "conv_clock_runs");
        // Eighteen conversion clock periods bound the window: at most 35 toggles.
        check(32'(t <= 35), 32'h1, "conv_bounded");
        repeat (20) @(negedge core_clk);
        check(busy, 1'b0, "busy_idle");
        if (!pd && en)
        begin
            if (q.size() < 8)
                q.push_back({4'h0, code_b, 4'h0, code_a});
            else
                ovf = 1'b1;
        end
        check(overflow, ovf, "overflow");
    endtask

    // Empties the FIFO and compares each word with the queue, most significant bit first, zero filled.
    task automatic drain();
        int n;
        @(posedge core_clk) res_ready <= 1'b1;
        n = 0;
        while (q.size() > 0 && n < 200)
        begin
            @(negedge core_clk);
            n++;
            if (res_valid === 1'b1)
                check(res_data, q.pop_front(), "res_data");
        end
        @(posedge core_clk) res_ready <= 1'b0;
        @(negedge core_clk);
        check(res_valid, 1'b0, "fifo_empty");
        check(q.size(), 0, "words_missing");
    endtask

    // Main sequence.
    initial
    begin
        repeat (4) @(negedge core_clk);
        check({conv_cs_b, conversion_clock, res_valid, overflow, busy}, 5'h18, "reset_pins");
        check(rx_word_length, 4'hF, "reset_wlen");
        check(rx_clock_edge_select, 1'b0, "edge_select");
        check(rx_frame_polarity, 1'b1, "frame_polarity");
        repeat (4) @(posedge core_clk);
        rst_b <= 1'b1;
        void'($urandom(67));
        for (k = 0; k < 4; k++)
            run(k[0], 1'b0, k[1], 1'b1);
        drain();
        $display("test words done");
        run(1'b0, 1'b1, 1'b0, 1'b1);
        drain();
        $display("test power_down done");
        run(1'b0, 1'b0, 1'b0, 1'b0);
        drain();
        $display("test disabled done");
        for (k = 0; k < 9; k++)
            run(1'b0, 1'b0, k[0], 1'b1);
        drain();
        $display("test overflow done");
        end_sim();
    end
endmodule // testbench
